// ==== hdl/cgc_clock_ctrl.sv ====
// Clock generator control: AHB-Lite registers, reference selection, bit, line and frame sync clocks
`timescale 1ns/10ps

module cgc_clock_ctrl
  import cgc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Straps
  input wire logic strap_pcm_master,
  input wire logic strap_internal_src,
  // Reference pins
  input wire logic external_reference_input,
  input wire logic reference_pin_i,
  output logic reference_pin_o,
  output logic reference_pin_oe,
  input wire logic pcm_frame_sync_i,
  // Generated clocks and the latched PCM master strap
  output logic osc_reference,
  output logic fast_pcm_bit_clock,
  output logic pcm_data_bit_clock,
  output logic frame_sync,
  output logic line_clock,
  output logic pcm_pins_master
);

  typedef enum logic [1:0] {FS_IDLE, FS_ARMED, FS_HIGH} cgc_fs_state_t;

  typedef struct packed {
    logic ref_en;
    logic [2:0] ref_sel;
    logic refpin_oe;
    logic [2:0] refpin_div;
    logic [2:0] div_act;
    logic fbc_en;
    logic [1:0] fbc_rate;
    logic bc_en;
    logic [2:0] bc_rate;
    logic fs_en;
    logic fs_short;
    logic ext_dly;
    logic int_dly;
    logic lc_rate;
    logic lc_dis;
    logic wr_pend;
    logic [15:0] waddr;
    logic rd_wait;
    logic [15:0] raddr;
    logic [31:0] hrdata;
    logic hready;
    logic strap_done;
    logic strap_int;
    logic pcm_master;
    logic ext_s;
    logic rin_s;
    logic fsi_s;
    logic [7:0] cnt_pin;
    logic [7:0] cnt_192;
    logic [7:0] cnt_256;
    logic [7:0] cnt_64;
    cgc_fs_state_t fs_st;
    logic fs_short_l;
    logic [1:0] fs_cnt;
    logic fs_late;
    logic fbc_p;
    logic bc_p;
    logic fs_p;
    logic refpin_o;
    logic osc_ref;
    logic fbc_o;
    logic bc_o;
    logic fs_o;
    logic lc_o;
  } cgc_state_t;

  cgc_state_t s_q;
  cgc_state_t s_d;
  logic fbc_clk;
  logic bc_clk;
  logic bc_rise;
  logic lc_clk;
  logic frame_rise;
  logic ext_rise;
  logic rin_rise;
  logic fs_raw;
  logic fs_dly;
  logic fs_sel;
  logic [8:0] pin_n;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Byte address to register index; anything above the map is unmapped
  function automatic logic [15:0] map_addr(input logic [31:0] a);
    return (a[31:18] == 14'h0) ? a[17:2] : IDX_NONE;
  endfunction : map_addr

  // Edge counting divider: next count
  function automatic logic [7:0] div_next(input logic [7:0] cnt, input logic [8:0] n, input logic edge_in);
    logic [7:0] r;
    r = cnt;
    if (edge_in) begin
      r = ({1'b0, cnt} >= n - 9'h001) ? 8'h00 : cnt + 8'h01;
    end
    return r;
  endfunction : div_next

  // Edge counting divider: output high during the first half of the count
  function automatic logic div_high(input logic [7:0] cnt, input logic [8:0] n);
    return {1'b0, cnt} < (n >> 1);
  endfunction : div_high

  // Pin divider code to ratio
  function automatic logic [8:0] pin_ratio(input logic [2:0] code);
    logic [8:0] r;
    case (code)
      3'h0: r = N_256;
      3'h1: r = N_192;
      3'h2: r = N_4;
      3'h3: r = N_3;
      default: r = N_1;
    endcase
    return r;
  endfunction : pin_ratio

  // Rate code to phase step, one table per clock
  function automatic logic [31:0] fbc_step(input logic [1:0] code);
    case (code)
      2'h1: return nco_step(F_FBC_1);
      2'h2: return nco_step(F_FBC_2);
      default: return nco_step(F_FBC_0);
    endcase
  endfunction : fbc_step

  function automatic logic [31:0] bc_step(input logic [2:0] code);
    case (code)
      3'h0: return nco_step(F_BC_0);
      3'h1: return nco_step(F_BC_1);
      3'h2: return nco_step(F_BC_2);
      3'h4: return nco_step(F_BC_4);
      default: return nco_step(F_BC_3);
    endcase
  endfunction : bc_step

  // Register read value; fields not listed stay zero
  function automatic logic [15:0] rd_value(input logic [15:0] idx, input cgc_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    case (idx)
      IDX_OSC_REF_SEL: begin
        v[REF_EN_BIT] = s.ref_en;
        v[REF_SEL_LSB +: 3] = s.ref_sel;
      end
      IDX_REFPIN_CTRL: begin
        v[PIN_OE_BIT] = s.refpin_oe;
        v[PIN_DIV_LSB +: 3] = s.refpin_div;
      end
      IDX_FAST_BCLK: begin
        v[FBC_EN_BIT] = s.fbc_en;
        v[FBC_RATE_LSB +: 2] = s.fbc_rate;
      end
      IDX_BCLK: begin
        v[BC_EN_BIT] = s.bc_en;
        v[BC_RATE_LSB +: 3] = s.bc_rate;
      end
      IDX_FSYNC: begin
        v[FS_INT_DLY_BIT] = s.int_dly;
        v[FS_EXT_DLY_BIT] = s.ext_dly;
        v[FS_EN_BIT] = s.fs_en;
        v[FS_SHORT_BIT] = s.fs_short;
      end
      IDX_LINE_CLK: begin
        v[LC_DIS_BIT] = s.lc_dis;
        v[LC_RATE_BIT] = s.lc_rate;
      end
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : rd_value

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  cgc_nco u_fast_bclk (.hclk(hclk), .hresetn(hresetn), .enable(s_q.fbc_en), .step(fbc_step(s_q.fbc_rate)),
                       .clk_out(fbc_clk), .rise());
  cgc_nco u_bclk (.hclk(hclk), .hresetn(hresetn), .enable(s_q.bc_en), .step(bc_step(s_q.bc_rate)),
                  .clk_out(bc_clk), .rise(bc_rise));
  cgc_nco u_line_clk (.hclk(hclk), .hresetn(hresetn), .enable(~s_q.lc_dis),
                      .step(s_q.lc_rate ? nco_step(F_LC_1) : nco_step(F_LC_0)),
                      .clk_out(lc_clk), .rise());
  cgc_nco u_frame (.hclk(hclk), .hresetn(hresetn), .enable(1'b1), .step(nco_step(FRAME_HZ)),
                   .clk_out(), .rise(frame_rise));

  // Edge detects: live pin level against its sample from the last cycle
  assign ext_rise = external_reference_input & ~s_q.ext_s;
  // Rising edge only; a level test here would count every high cycle of the pin
  assign rin_rise = ~s_q.rin_s & ~s_q.refpin_oe & reference_pin_i;
  assign pin_n = pin_ratio(s_q.div_act);
  // Sync raw level and its rising-edge delay option
  assign fs_raw = (s_q.fs_st == FS_HIGH);
  assign fs_dly = s_q.ext_dly | (s_q.int_dly & s_q.strap_int);
  assign fs_sel = fs_dly ? (fs_raw & s_q.fs_late) : fs_raw;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Straps are caught once, on the first edge after reset release
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.strap_int = strap_internal_src;
      s_d.pcm_master = strap_pcm_master;
    end
    // Bus address phase; reads take one wait state so a write just before is seen
    s_d.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        s_d.wr_pend = 1'b1;
        s_d.waddr = map_addr(haddr);
      end else begin
        s_d.rd_wait = 1'b1;
        s_d.raddr = map_addr(haddr);
        s_d.hready = 1'b0;
      end
    end
    if (s_q.rd_wait) begin
      s_d.rd_wait = 1'b0;
      s_d.hready = 1'b1;
      s_d.hrdata = {16'h0000, rd_value(s_q.raddr, s_q)};
    end
    // Write data phase; reserved codes leave the field unchanged
    if (s_q.wr_pend) begin
      case (s_q.waddr)
        IDX_OSC_REF_SEL: begin
          s_d.ref_en = hwdata[REF_EN_BIT];
          if (hwdata[REF_SEL_LSB +: 3] <= SEL_MAX) s_d.ref_sel = hwdata[REF_SEL_LSB +: 3];
        end
        IDX_REFPIN_CTRL: begin
          s_d.refpin_oe = hwdata[PIN_OE_BIT];
          if (hwdata[PIN_DIV_LSB +: 3] <= DIV_MAX) s_d.refpin_div = hwdata[PIN_DIV_LSB +: 3];
        end
        IDX_FAST_BCLK: begin
          s_d.fbc_en = hwdata[FBC_EN_BIT];
          if (hwdata[FBC_RATE_LSB +: 2] <= FBC_MAX) s_d.fbc_rate = hwdata[FBC_RATE_LSB +: 2];
        end
        IDX_BCLK: begin
          s_d.bc_en = hwdata[BC_EN_BIT];
          if (hwdata[BC_RATE_LSB +: 3] <= BC_MAX) s_d.bc_rate = hwdata[BC_RATE_LSB +: 3];
        end
        IDX_FSYNC: begin
          s_d.int_dly = hwdata[FS_INT_DLY_BIT];
          s_d.ext_dly = hwdata[FS_EXT_DLY_BIT];
          s_d.fs_en = hwdata[FS_EN_BIT];
          s_d.fs_short = hwdata[FS_SHORT_BIT];
        end
        IDX_LINE_CLK: begin
          s_d.lc_dis = hwdata[LC_DIS_BIT];
          s_d.lc_rate = hwdata[LC_RATE_BIT];
        end
        default: s_d.wr_pend = s_d.wr_pend;
      endcase
    end
    // Pin samples; the pin only counts as a source while it is an input
    s_d.ext_s = external_reference_input;
    s_d.rin_s = ~s_q.refpin_oe & reference_pin_i;
    s_d.fsi_s = ~s_q.pcm_master & pcm_frame_sync_i;
    // Dividers of the external reference and of the pin input
    s_d.cnt_192 = div_next(s_q.cnt_192, N_192, ext_rise);
    s_d.cnt_256 = div_next(s_q.cnt_256, N_256, ext_rise);
    s_d.cnt_64 = div_next(s_q.cnt_64, N_64, rin_rise);
    s_d.cnt_pin = div_next(s_q.cnt_pin, pin_n, ext_rise);
    // A new pin ratio is adopted only when the count wraps
    if (ext_rise && s_d.cnt_pin == 8'h00) s_d.div_act = s_q.refpin_div;
    // Reference pin driver; follows the new enable so no data stands once the driver is off
    if (!s_d.refpin_oe) begin
      s_d.refpin_o = 1'b0;
    end else if (s_q.div_act == DIV_BY_ONE) begin
      s_d.refpin_o = s_q.ext_s;
    end else begin
      s_d.refpin_o = div_high(s_q.cnt_pin, pin_n);
    end
    // Oscillator reference mux and gate
    case (s_q.ref_sel)
      SRC_EXT_192: s_d.osc_ref = div_high(s_q.cnt_192, N_192);
      SRC_EXT_256: s_d.osc_ref = div_high(s_q.cnt_256, N_256);
      SRC_EXT: s_d.osc_ref = s_q.ext_s;
      SRC_PIN: s_d.osc_ref = s_q.rin_s;
      SRC_PIN_64: s_d.osc_ref = div_high(s_q.cnt_64, N_64);
      SRC_FSYNC: s_d.osc_ref = s_q.fsi_s;
      default: s_d.osc_ref = 1'b0;
    endcase
    s_d.osc_ref = s_d.osc_ref & s_q.ref_en;
    // Frame sync: armed by the frame tick, opened on a bit clock edge
    case (s_q.fs_st)
      FS_IDLE: begin
        if (frame_rise) s_d.fs_st = FS_ARMED;
      end
      FS_ARMED: begin
        if (bc_rise) begin
          s_d.fs_st = FS_HIGH;
          s_d.fs_cnt = 2'h0;
          s_d.fs_short_l = s_q.fs_short;
        end
      end
      FS_HIGH: begin
        if (bc_rise) begin
          s_d.fs_cnt = s_q.fs_cnt + 2'h1;
          if (s_d.fs_cnt == (s_q.fs_short_l ? FS_SHORT_LEN : FS_LONG_LEN)) s_d.fs_st = FS_IDLE;
        end
      end
      default: s_d.fs_st = FS_IDLE;
    endcase
    if (!s_q.fs_en) s_d.fs_st = FS_IDLE;
    s_d.fs_late = fs_raw;
    // Strap bit 0 low adds one core clock to the PCM side clocks
    s_d.fbc_p = fbc_clk;
    s_d.bc_p = bc_clk;
    s_d.fs_p = fs_sel;
    s_d.fbc_o = s_q.strap_int ? fbc_clk : s_q.fbc_p;
    s_d.bc_o = s_q.strap_int ? bc_clk : s_q.bc_p;
    s_d.fs_o = s_q.strap_int ? fs_sel : s_q.fs_p;
    s_d.lc_o = lc_clk;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ref_en <= RST_OSC_REF_SEL[REF_EN_BIT];
      s_q.ref_sel <= RST_OSC_REF_SEL[REF_SEL_LSB +: 3];
      s_q.refpin_oe <= RST_REFPIN_CTRL[PIN_OE_BIT];
      s_q.refpin_div <= RST_REFPIN_CTRL[PIN_DIV_LSB +: 3];
      s_q.div_act <= RST_REFPIN_CTRL[PIN_DIV_LSB +: 3];
      s_q.fbc_en <= RST_FAST_BCLK[FBC_EN_BIT];
      s_q.fbc_rate <= RST_FAST_BCLK[FBC_RATE_LSB +: 2];
      s_q.bc_en <= RST_BCLK[BC_EN_BIT];
      s_q.bc_rate <= RST_BCLK[BC_RATE_LSB +: 3];
      s_q.fs_en <= RST_FSYNC[FS_EN_BIT];
      s_q.fs_short <= RST_FSYNC[FS_SHORT_BIT];
      s_q.lc_rate <= RST_LINE_CLK[LC_RATE_BIT];
      s_q.lc_dis <= RST_LINE_CLK[LC_DIS_BIT];
      s_q.fs_st <= FS_IDLE;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs, all straight from the state register
  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.hready;
  assign hresp = s_q.hrdata[31] & 1'b0;
  assign reference_pin_o = s_q.refpin_o;
  assign reference_pin_oe = s_q.refpin_oe;
  assign osc_reference = s_q.osc_ref;
  assign fast_pcm_bit_clock = s_q.fbc_o;
  assign pcm_data_bit_clock = s_q.bc_o;
  assign frame_sync = s_q.fs_o;
  assign line_clock = s_q.lc_o;
  assign pcm_pins_master = s_q.pcm_master;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ref_gate_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_q.ref_en |=> !osc_reference) else $error("reference passed while disabled");
  a_ref_src_ext: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.ref_en && s_q.ref_sel == SRC_EXT) |=> osc_reference == $past(external_reference_input, 2))
    else $error("undivided reference not passed");
  a_pin_in_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    !reference_pin_oe |-> !reference_pin_o) else $error("pin data while not driving");
  a_fs_held_low: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_q.fs_en [*3] |=> !frame_sync) else $error("frame sync while disabled");
  a_fs_short_end: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.fs_st == FS_HIGH && s_q.fs_short_l && bc_rise) |=> s_q.fs_st == FS_IDLE)
    else $error("short sync pulse too long");
  a_fs_long_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.fs_en && s_q.fs_st == FS_HIGH && !s_q.fs_short_l && bc_rise && s_q.fs_cnt == 2'h0)
    |=> s_q.fs_st == FS_HIGH) else $error("long sync pulse too short");
  a_fs_rise_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    ((s_q.ext_dly || s_q.int_dly) && s_q.strap_int && fs_raw && !s_q.fs_late) |=> !frame_sync)
    else $error("sync rising edge not delayed");
  a_fs_no_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    (!s_q.ext_dly && !s_q.int_dly && s_q.strap_int && fs_raw && !s_q.fs_late) |=> frame_sync)
    else $error("sync delayed without cause");
  // Strap low: the internal delay bit is ignored, only the strap's one-cycle lag remains
  a_fs_int_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    (!s_q.ext_dly && !s_q.strap_int && fs_raw && !s_q.fs_late) |-> ##2 frame_sync)
    else $error("internal sync delay applied without strap");
  a_rd_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:4] == 28'h0) else $error("unused read bits not zero");
  a_sel_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_q.wr_pend && s_q.waddr == IDX_OSC_REF_SEL && hwdata[2:0] > SEL_MAX) |=> $stable(s_q.ref_sel))
    else $error("reserved select code taken");
  a_line_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.lc_dis [*8] |=> !line_clock) else $error("line clock runs while disabled");

endmodule : cgc_clock_ctrl

// ==== hdl/cgc_pkg.sv ====
// Package: register map, field layout, reset values and rate tables of the clock generator control
package cgc_pkg;

  // ----------------------------------------------------------------
  // Core clock and timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CORE_TICK_NS = 16;
  // One-tick sync delay rounded up to whole core clocks, never below one
  localparam int unsigned SYNC_DELAY_CYC = (CORE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint unsigned FRAME_HZ = 8_000;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_OSC_REF_SEL = 16'hd083;
  localparam logic [15:0] IDX_REFPIN_CTRL = 16'hd084;
  localparam logic [15:0] IDX_FAST_BCLK = 16'hd085;
  localparam logic [15:0] IDX_BCLK = 16'hd086;
  localparam logic [15:0] IDX_FSYNC = 16'hd087;
  localparam logic [15:0] IDX_LINE_CLK = 16'hd088;
  localparam logic [15:0] IDX_NONE = 16'h0000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_OSC_REF_SEL = 16'h0000;
  localparam logic [15:0] RST_REFPIN_CTRL = 16'h0003;
  localparam logic [15:0] RST_FAST_BCLK = 16'h0004;
  localparam logic [15:0] RST_BCLK = 16'h000b;
  localparam logic [15:0] RST_FSYNC = 16'h0002;
  localparam logic [15:0] RST_LINE_CLK = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions and largest legal codes
  // ----------------------------------------------------------------
  localparam int REF_EN_BIT = 3;
  localparam int REF_SEL_LSB = 0;
  localparam int PIN_OE_BIT = 3;
  localparam int PIN_DIV_LSB = 0;
  localparam int FBC_EN_BIT = 2;
  localparam int FBC_RATE_LSB = 0;
  localparam int BC_EN_BIT = 3;
  localparam int BC_RATE_LSB = 0;
  localparam int FS_INT_DLY_BIT = 3;
  localparam int FS_EXT_DLY_BIT = 2;
  localparam int FS_EN_BIT = 1;
  localparam int FS_SHORT_BIT = 0;
  localparam int LC_DIS_BIT = 1;
  localparam int LC_RATE_BIT = 0;
  localparam logic [2:0] SEL_MAX = 3'h5;
  localparam logic [2:0] DIV_MAX = 3'h4;
  localparam logic [1:0] FBC_MAX = 2'h2;
  localparam logic [2:0] BC_MAX = 3'h4;
  localparam logic [2:0] DIV_BY_ONE = 3'h4;

  // ----------------------------------------------------------------
  // Source selections and divider ratios
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_EXT_192 = 3'h0;
  localparam logic [2:0] SRC_EXT_256 = 3'h1;
  localparam logic [2:0] SRC_EXT = 3'h2;
  localparam logic [2:0] SRC_PIN = 3'h3;
  localparam logic [2:0] SRC_PIN_64 = 3'h4;
  localparam logic [2:0] SRC_FSYNC = 3'h5;
  localparam logic [8:0] N_192 = 9'h0c0;
  localparam logic [8:0] N_256 = 9'h100;
  localparam logic [8:0] N_64 = 9'h040;
  localparam logic [8:0] N_4 = 9'h004;
  localparam logic [8:0] N_3 = 9'h003;
  localparam logic [8:0] N_1 = 9'h001;
  // Bit clock rising edges per frame sync pulse
  localparam logic [1:0] FS_SHORT_LEN = 2'h1;
  localparam logic [1:0] FS_LONG_LEN = 2'h3;

  // ----------------------------------------------------------------
  // Output rates in Hz
  // ----------------------------------------------------------------
  localparam longint unsigned F_FBC_0 = 3_072_000;
  localparam longint unsigned F_FBC_1 = 6_144_000;
  localparam longint unsigned F_FBC_2 = 12_288_000;
  localparam longint unsigned F_BC_0 = 384_000;
  localparam longint unsigned F_BC_1 = 768_000;
  localparam longint unsigned F_BC_2 = 1_536_000;
  localparam longint unsigned F_BC_3 = 2_048_000;
  localparam longint unsigned F_BC_4 = 4_096_000;
  localparam longint unsigned F_LC_0 = 7_680_000;
  localparam longint unsigned F_LC_1 = 15_360_000;

  // Phase step of a 32-bit accumulator for a given output rate
  function automatic logic [31:0] nco_step(input longint unsigned f_hz);
    longint unsigned s;
    s = (f_hz << 32) / CLK_HZ;
    return s[31:0];
  endfunction : nco_step

endpackage : cgc_pkg

// ==== hdl/cgc_nco.sv ====
// Phase accumulator clock source with boundary-aligned enable
`timescale 1ns/10ps
module cgc_nco
  import cgc_pkg::*;
#(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic enable,
  input wire logic [W-1:0] step,
  // Generated clock and its ungated rising-edge pulse
  output logic clk_out,
  output logic rise
);

  typedef struct packed {
    logic [W-1:0] acc;
    logic run;
    logic out;
    logic rise;
  } cgc_nco_state_t;

  cgc_nco_state_t s_q;
  cgc_nco_state_t s_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Enable is only sampled in the low half so a pulse is never cut short
  always_comb begin
    s_d = s_q;
    s_d.acc = s_q.acc + step;
    s_d.run = s_d.acc[W-1] ? s_q.run : enable;
    s_d.out = s_d.acc[W-1] & s_d.run;
    s_d.rise = s_d.acc[W-1] & ~s_q.acc[W-1];
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_out = s_q.out;
  assign rise = s_q.rise;

endmodule : cgc_nco

// ==== tb/cgc_far_end.sv ====
// Far-end model: reference source and reference pad
`timescale 1ns/10ps
module cgc_far_end (
  // Clock
  input wire logic hclk,
  // Pad from the device
  input wire logic pin_o,
  input wire logic pin_oe,
  // Levels seen by the device
  output logic xref,
  output logic pad
);
  logic [4:0] n_q = 5'h0;
  // Phase counter; a 2 MHz reference stays inside the 2.048 MHz ceiling
  always_ff @(posedge hclk) n_q <= (n_q == 5'h13) ? 5'h0 : n_q + 5'h1;
  assign xref = (n_q % 5'ha) < 5'h5;
  // Pad follows the device only while driven, else our own 1 MHz source
  assign pad = pin_oe ? pin_o : (n_q < 5'ha);
endmodule : cgc_far_end

// ==== tb/cgc_clock_ctrl_test.sv ====
// Testbench: register access and clock rate checks
`timescale 1ns/10ps
module cgc_clock_ctrl_test import cgc_pkg::*; ;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire [31:0] hrdata;
  wire hready, hresp, xref, pad, pin_o, pin_oe, pm;
  wire [5:0] mon;
  logic [5:0] prev = 6'h0;
  logic [1:0] strap = 2'h1; // Bit 1 PCM master, bit 0 internal source
  logic [15:0] cnt[6] = '{default: 16'h0};
  logic [15:0] snap[6];
  int bad_count = 0, n_tests = 0;
  localparam logic [15:0] IX[6] = '{16'hd083, 16'hd084, 16'hd085, 16'hd086, 16'hd087, 16'hd088};
  localparam logic [15:0] RV[6] = '{16'h0000, 16'h0003, 16'h0004, 16'h000b, 16'h0002, 16'h0000};
  localparam logic [15:0] FV[6] = '{16'h0008, 16'h000b, 16'h0004, 16'h000b, 16'h000f, 16'h0003};

  cgc_clock_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .strap_pcm_master(strap[1]), .strap_internal_src(strap[0]), .external_reference_input(xref),
    .reference_pin_i(pad), .reference_pin_o(pin_o), .reference_pin_oe(pin_oe), .pcm_frame_sync_i(mon[0]),
    .osc_reference(mon[4]), .fast_pcm_bit_clock(mon[3]), .pcm_data_bit_clock(mon[2]), .frame_sync(mon[0]),
    .line_clock(mon[1]), .pcm_pins_master(pm));
  cgc_far_end far (.hclk(hclk), .pin_o(pin_o), .pin_oe(pin_oe), .xref(xref), .pad(pad));
  assign mon[5] = pin_o;

  // Free-running edge counters; a window is the difference of two snapshots
  always @(posedge hclk) begin
    prev <= mon;
    for (int i = 0; i < 6; i++)
      if (mon[i] & !prev[i]) cnt[i] <= cnt[i] + 16'h1;
  end

  initial forever #25 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {14'h0, idx, 2'h0};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Write one register, then count output edges over 4000 cycles; NCO phase allows one edge of slack
  task automatic step(input logic [15:0] idx, input logic [15:0] wd, input logic [15:0] e[6]);
    logic [15:0] g;
    ahb(1'b1, idx, wd);
    snap = cnt;
    repeat (4000) @(posedge hclk);
    for (int i = 0; i < 6; i++) begin
      g = cnt[i] - snap[i];
      n_tests++;
      if ((g + 16'h1 >= e[i] && g <= e[i] + 16'h1) !== 1'b1) begin
        bad_count++;
        $display("[FAIL] edges of output %0d expected %0d seen %0d", i, e[i], g);
      end
    end
    $display("test %h %h done", idx, wd);
  endtask : step

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (80000) @(posedge hclk);
    bad_count++;
    print_verdict;
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (IX[i]) begin
      ahb(1'b0, IX[i], 16'h0);
      chk("reset value", {16'h0, RV[i]}, rd);
    end
    chk("pin master", 32'h0, {31'h0, pm});
    ahb(1'b0, 16'hd090, 16'h0);
    chk("unmapped read", 32'h0, rd);
    $display("reset test done");
    step(16'hd090, 16'hffff, '{2, 1536, 410, 614, 0, 0});
    foreach (IX[i]) begin
      ahb(1'b1, IX[i], 16'hffff);
      ahb(1'b0, IX[i], 16'h0);
      chk("masked value", {16'h0, FV[i]}, rd);
    end
    chk("response", 32'h0, {31'h0, hresp});
    step(16'hd086, 16'h0008, '{2, 0, 77, 614, 2, 133});
    step(16'hd086, 16'h0009, '{2, 0, 154, 614, 2, 133});
    step(16'hd086, 16'h000a, '{2, 0, 307, 614, 2, 133});
    step(16'hd086, 16'h000c, '{2, 0, 819, 614, 2, 133});
    step(16'hd087, 16'h0000, '{0, 0, 819, 614, 2, 133});
    step(16'hd086, 16'h0004, '{0, 0, 0, 614, 2, 133});
    step(16'hd085, 16'h0005, '{0, 0, 0, 1229, 2, 133});
    step(16'hd085, 16'h0001, '{0, 0, 0, 0, 2, 133});
    step(16'hd084, 16'h0004, '{0, 0, 0, 0, 2, 0});
    chk("pad enable", 32'h0, {31'h0, pin_oe});
    step(16'hd083, 16'h000b, '{0, 0, 0, 0, 200, 0});
    step(16'hd083, 16'h000c, '{0, 0, 0, 0, 3, 0});
    step(16'hd083, 16'h0009, '{0, 0, 0, 0, 2, 0});
    step(16'hd083, 16'h000a, '{0, 0, 0, 0, 400, 0});
    step(16'hd084, 16'h000a, '{0, 0, 0, 0, 400, 100});
    chk("pad enable", 32'h1, {31'h0, pin_oe});
    step(16'hd084, 16'h0008, '{0, 0, 0, 0, 400, 2});
    // Mid-run reset with opposite straps; the looped sync must be ignored in master mode
    strap <= 2'h2;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    step(16'hd087, 16'h000a, '{2, 1536, 410, 614, 0, 0});
    chk("pin master", 32'h1, {31'h0, pm});
    step(16'hd083, 16'h000d, '{2, 1536, 410, 614, 0, 0});
    print_verdict;
  end
endmodule : cgc_clock_ctrl_test
